// ===== common/gpt32_pkg.sv
package gpt32_pkg;

    // ****************************************
    // Count clock choice
    // ****************************************
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_LFOSC = 2'h1;
    localparam logic [1:0] CLK_UNDIV = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;

    // ****************************************
    // Prescaler choice and terminal counts
    // ****************************************
    localparam logic [1:0] PRE_DIV4 = 2'h0;
    localparam logic [1:0] PRE_DIV16 = 2'h1;
    localparam logic [1:0] PRE_DIV256 = 2'h2;
    localparam logic [1:0] PRE_DIV32K = 2'h3;
    localparam logic [14:0] DIV4_LAST = 15'h0003;
    localparam logic [14:0] DIV16_LAST = 15'h000F;
    localparam logic [14:0] DIV256_LAST = 15'h00FF;
    localparam logic [14:0] DIV32K_LAST = 15'h7FFF;
    localparam logic [14:0] PRE_RST = 15'h0000;

    // ****************************************
    // Counter values
    // ****************************************
    localparam logic [31:0] CNT_ZERO = 32'h00000000;
    localparam logic [31:0] CNT_FULL = 32'hFFFFFFFF;
    localparam logic [31:0] CNT_STEP = 32'h00000001;

    // ****************************************
    // Event flag positions
    // ****************************************
    localparam int EV_A = 0;
    localparam int EV_B = 1;
    localparam int EV_C = 2;
    localparam int EV_ROLL = 3;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [1:0] clk_choice;
        logic [1:0] prescale;
        logic free_run;
        logic freeze;
        logic count_down;
    } gpt32_cfg_t;

    localparam gpt32_cfg_t CFG_RST = '{2'h0, 2'h0, 1'b0, 1'b0, 1'b0};

    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } gpt32_state_t;

endpackage

// ===== design/gpt32_tick.sv
`timescale 1ns/100ps
module gpt32_tick
    import gpt32_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic lfosc_pin,
    input wire logic undiv_pin,
    input wire logic ext_pin,
    input wire logic [1:0] clk_choice,
    input wire logic [1:0] prescale,
    input wire logic run,
    output logic src_edge,
    output logic tick
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic rise_of(input logic [2:0] s);
        rise_of = s[1] & ~s[2];
    endfunction

    function automatic logic [14:0] div_last(input logic [1:0] p);
        if (p == PRE_DIV4)
            div_last = DIV4_LAST;
        else if (p == PRE_DIV16)
            div_last = DIV16_LAST;
        else if (p == PRE_DIV256)
            div_last = DIV256_LAST;
        else
            div_last = DIV32K_LAST;
    endfunction

    // ****************************************
    // Source synchronisers
    // ****************************************
    logic [2:0] lf_ff, nxt_lf;
    logic [2:0] ud_ff, nxt_ud;
    logic [2:0] ex_ff, nxt_ex;
    logic [14:0] pre_ff, nxt_pre;

    always_comb
    begin
        nxt_lf = {lf_ff[1:0], lfosc_pin};
        nxt_ud = {ud_ff[1:0], undiv_pin};
        nxt_ex = {ex_ff[1:0], ext_pin};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lf_ff <= 3'h0;
            ud_ff <= 3'h0;
            ex_ff <= 3'h0;
        end
        else if (clk_en)
        begin
            lf_ff <= nxt_lf;
            ud_ff <= nxt_ud;
            ex_ff <= nxt_ex;
        end
    end

    // ****************************************
    // Source select and prescaler
    // ****************************************
    always_comb
    begin
        if (clk_choice == CLK_BUS)
            src_edge = 1'b1;
        else if (clk_choice == CLK_LFOSC)
            src_edge = rise_of(lf_ff);
        else if (clk_choice == CLK_UNDIV)
            src_edge = rise_of(ud_ff);
        else
            src_edge = rise_of(ex_ff);
        tick = run && src_edge && (pre_ff == div_last(prescale));
        if (!run)
            nxt_pre = PRE_RST;
        else if (tick)
            nxt_pre = PRE_RST;
        else if (src_edge)
            nxt_pre = pre_ff + 15'h0001;
        else
            nxt_pre = pre_ff;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pre_ff <= PRE_RST;
        else if (clk_en)
            pre_ff <= nxt_pre;
    end

    chk_prescale_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && tick |=> pre_ff == PRE_RST)
        else $error("Prescaler did not restart after tick");

endmodule // gpt32_tick

// ===== design/gpt32_timer.sv
// Operation
// - Counter is 32 bits wide, counts up or down, maximum all ones.
// - Prescaler divides the chosen count clock by 4, 16, 256 or 32768.
// - Count clock is low frequency oscillator, system clock, bus clock or external.
// - Free-running mode spans the full range and wraps to the opposite extreme.
// - Periodic mode counts to limit C, then restarts toward it again.
// - Compare values A and B add timeouts; each timeout is separately enabled.
// - Run bit high starts counting; run bit low stops at any moment.
// - Counting up starts at zero; at limit C raise event and return to zero.
// - Counting down loads full scale, decrements to limit C, raises event if enabled.
// - Count is read as two separate 16-bit halves at any time.
// - With freeze set, low-half read holds both halves until high half read.
// - Writing one to a clear bit removes the matching pending event.
// - Only in free-running mode a rollover raises the enabled event.
// - Software waits for the synchronised enable status low before reconfiguring.
// - Run control crosses into the count domain through two flip-flops.
// - Clock choice 00 bus, 01 oscillator, 10 system clock, 11 external.
// - Direction 0 counts up from zero, 1 counts down from full scale.
// - Mode 0 is periodic against limit C, 1 is free-running.
`timescale 1ns/100ps
module gpt32_timer
    import gpt32_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic LFOSC_CLK,
    input wire logic UNDIVIDED_SYSTEM_CLOCK,
    input wire logic EXTERNAL_COUNT_CLOCK,
    input wire logic COUNTER_RUN_CONTROL,
    input wire logic [1:0] COUNT_CLOCK_CHOICE,
    input wire logic [1:0] PRESCALE_CHOICE,
    input wire logic FREE_RUN,
    input wire logic FREEZE_ENABLE,
    input wire logic COUNT_DIRECTION,
    input wire logic [31:0] TIMEOUT_A,
    input wire logic [31:0] TIMEOUT_B,
    input wire logic [15:0] PERIOD_LIMIT_LOW,
    input wire logic [15:0] PERIOD_LIMIT_HIGH,
    input wire logic [3:0] EVENT_ENABLE,
    input wire logic [3:0] COUNTER_EVENT_CLEAR,
    input wire logic READ_LOW,
    input wire logic READ_HIGH,
    output logic [15:0] COUNT_LOW_HALF,
    output logic [15:0] COUNT_HIGH_HALF,
    output logic [3:0] COUNTER_EVENT_FLAGS,
    output logic ENABLE_SYNCED,
    output logic TIMER_IRQ
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ****************************************
    // Count clock and prescaler
    // ****************************************
    logic src_edge;
    logic tick;
    logic en_meta_ff, nxt_en_meta;
    logic en_sync_ff, nxt_en_sync;
    gpt32_cfg_t cfg_ff, nxt_cfg;

    gpt32_tick u_tick (
        .clk(REF_CLK),
        .rst_n(rst_n_ff),
        .clk_en(CLK_EN),
        .lfosc_pin(LFOSC_CLK),
        .undiv_pin(UNDIVIDED_SYSTEM_CLOCK),
        .ext_pin(EXTERNAL_COUNT_CLOCK),
        .clk_choice(cfg_ff.clk_choice),
        .prescale(cfg_ff.prescale),
        .run(en_sync_ff),
        .src_edge(src_edge),
        .tick(tick)
    );

    // ****************************************
    // Run control crossing and configuration
    // ****************************************
    always_comb
    begin
        nxt_en_meta = en_meta_ff;
        nxt_en_sync = en_sync_ff;
        nxt_cfg = cfg_ff;
        if (src_edge)
        begin
            nxt_en_meta = COUNTER_RUN_CONTROL;
            nxt_en_sync = en_meta_ff;
        end
        if (!en_sync_ff && !COUNTER_RUN_CONTROL)
        begin
            nxt_cfg.clk_choice = COUNT_CLOCK_CHOICE;
            nxt_cfg.prescale = PRESCALE_CHOICE;
            nxt_cfg.free_run = FREE_RUN;
            nxt_cfg.freeze = FREEZE_ENABLE;
            nxt_cfg.count_down = COUNT_DIRECTION;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            en_meta_ff <= 1'b0;
            en_sync_ff <= 1'b0;
            cfg_ff <= CFG_RST;
        end
        else if (CLK_EN)
        begin
            en_meta_ff <= nxt_en_meta;
            en_sync_ff <= nxt_en_sync;
            cfg_ff <= nxt_cfg;
        end
    end

    assign ENABLE_SYNCED = en_sync_ff;

    // ****************************************
    // Counter state machine
    // ****************************************
    gpt32_state_t st_ff, nxt_st;
    logic [31:0] cnt_ff, nxt_cnt;
    logic [31:0] limit_c;
    logic [31:0] start_val;
    logic [3:0] events;

    always_comb
    begin
        limit_c = {PERIOD_LIMIT_HIGH, PERIOD_LIMIT_LOW};
        start_val = cfg_ff.count_down ? CNT_FULL : CNT_ZERO;
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        events = 4'h0;
        case (st_ff)
            ST_OFF:
            begin
                if (en_sync_ff)
                begin
                    nxt_st = ST_RUN;
                    nxt_cnt = start_val;
                end
            end
            ST_RUN:
            begin
                if (!en_sync_ff)
                    nxt_st = ST_OFF;
                else if (tick)
                begin
                    events[EV_A] = (cnt_ff == TIMEOUT_A);
                    events[EV_B] = (cnt_ff == TIMEOUT_B);
                    events[EV_C] = !cfg_ff.free_run && (cnt_ff == limit_c);
                    events[EV_ROLL] = cfg_ff.free_run &&
                        (cnt_ff == (cfg_ff.count_down ? CNT_ZERO : CNT_FULL));
                    if (events[EV_C])
                        nxt_cnt = start_val;
                    else if (cfg_ff.count_down)
                        nxt_cnt = cnt_ff - CNT_STEP;
                    else
                        nxt_cnt = cnt_ff + CNT_STEP;
                end
            end
            default:
            begin
                nxt_st = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            st_ff <= ST_OFF;
            cnt_ff <= CNT_ZERO;
        end
        else if (CLK_EN)
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // ****************************************
    // Event flags
    // ****************************************
    logic [3:0] flags_ff, nxt_flags;

    always_comb
    begin
        nxt_flags = (flags_ff & ~COUNTER_EVENT_CLEAR) | (events & EVENT_ENABLE);
    end

    always_ff @(posedge REF_CLK or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            flags_ff <= FLAGS_RST;
        else if (CLK_EN)
            flags_ff <= nxt_flags;
    end

    assign COUNTER_EVENT_FLAGS = flags_ff;
    assign TIMER_IRQ = |flags_ff;

    // ****************************************
    // Count readout halves
    // ****************************************
    logic frozen_ff, nxt_frozen;
    logic [15:0] lo_ff, nxt_lo;
    logic [15:0] hi_ff, nxt_hi;

    always_comb
    begin
        nxt_frozen = frozen_ff;
        if (READ_HIGH)
            nxt_frozen = 1'b0;
        else if (READ_LOW && cfg_ff.freeze)
            nxt_frozen = 1'b1;
        nxt_lo = frozen_ff ? lo_ff : cnt_ff[15:0];
        nxt_hi = frozen_ff ? hi_ff : cnt_ff[31:16];
        if (READ_LOW && cfg_ff.freeze && !frozen_ff)
        begin
            nxt_lo = lo_ff;
            nxt_hi = hi_ff;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            frozen_ff <= 1'b0;
            lo_ff <= 16'h0000;
            hi_ff <= 16'h0000;
        end
        else if (CLK_EN)
        begin
            frozen_ff <= nxt_frozen;
            lo_ff <= nxt_lo;
            hi_ff <= nxt_hi;
        end
    end

    assign COUNT_LOW_HALF = lo_ff;
    assign COUNT_HIGH_HALF = hi_ff;

    // ****************************************
    // Checks
    // ****************************************
    chk_enable_two_flops: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        CLK_EN && src_edge && en_sync_ff != en_meta_ff |=> en_sync_ff == $past(en_meta_ff))
        else $error("Synchronised enable did not follow first stage");
    chk_status_falls: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        $fell(ENABLE_SYNCED) |-> !$past(en_meta_ff))
        else $error("Enable status fell without stop request");
    chk_start_value: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        $rose(st_ff == ST_RUN) |-> cnt_ff == (cfg_ff.count_down ? CNT_FULL : CNT_ZERO))
        else $error("Counter did not start at its start value");
    chk_stopped_holds: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        st_ff == ST_OFF && $past(st_ff) == ST_OFF && !en_sync_ff |=> $stable(cnt_ff))
        else $error("Counter moved while stopped");
    chk_period_up: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        CLK_EN && st_ff == ST_RUN && en_sync_ff && tick && !cfg_ff.free_run
        && !cfg_ff.count_down && cnt_ff == limit_c |=> cnt_ff == CNT_ZERO)
        else $error("Periodic up count did not restart at zero");
    chk_period_down: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        CLK_EN && st_ff == ST_RUN && en_sync_ff && tick && !cfg_ff.free_run
        && cfg_ff.count_down && cnt_ff == limit_c |=> cnt_ff == CNT_FULL)
        else $error("Periodic down count did not reload full scale");
    chk_free_roll: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        CLK_EN && st_ff == ST_RUN && en_sync_ff && tick && cfg_ff.free_run
        && !cfg_ff.count_down && cnt_ff == CNT_FULL && EVENT_ENABLE[EV_ROLL]
        |=> cnt_ff == CNT_ZERO && flags_ff[EV_ROLL])
        else $error("Free-running rollover missed");
    chk_compare_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        CLK_EN && st_ff == ST_RUN && en_sync_ff && tick && cnt_ff == TIMEOUT_A
        && EVENT_ENABLE[EV_A] |=> flags_ff[EV_A] && TIMER_IRQ)
        else $error("Compare A event lost");
    chk_clear_flag: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        CLK_EN && COUNTER_EVENT_CLEAR[EV_C] && !events[EV_C] |=> !flags_ff[EV_C])
        else $error("Clear did not remove event C");
    chk_freeze_hold: assert property (@(posedge REF_CLK) disable iff (!rst_n_ff)
        CLK_EN && frozen_ff && !READ_HIGH |=> $stable(lo_ff) && $stable(hi_ff))
        else $error("Frozen halves changed");

endmodule // gpt32_timer

// ===== sim/gpt32_timer_test.sv
`timescale 1ns/100ps
module gpt32_timer_test;
    import gpt32_pkg::*;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic ref_clk, resetn, run, freeze, free_run, dir, rd_lo, rd_hi;
    logic [1:0] choice, presc;
    logic [31:0] to_a, to_b, lim_c, mn, mx, gap;
    logic [31:0] cyc = 32'h0;
    logic [3:0] ev_en, ev_clr, flags;
    logic [15:0] cnt_lo, cnt_hi, lo_save, hi_save;
    logic synced, irq;
    int mismatches, checked;
    logic [1:0] src_t [6] = '{CLK_BUS, CLK_BUS, CLK_BUS, CLK_LFOSC, CLK_UNDIV, CLK_EXT};
    logic [1:0] pre_t [6] = '{PRE_DIV4, PRE_DIV16, PRE_DIV256, PRE_DIV4, PRE_DIV4, PRE_DIV16};
    logic [31:0] gap_t [6] = '{32'h4, 32'h10, 32'h100, 32'h40, 32'h10, 32'h80};

    gpt32_timer uut (
        .REF_CLK(ref_clk), .RESETN(resetn), .CLK_EN(1'b1),
        .LFOSC_CLK(cyc[3]), .UNDIVIDED_SYSTEM_CLOCK(cyc[1]), .EXTERNAL_COUNT_CLOCK(cyc[2]),
        .COUNTER_RUN_CONTROL(run), .COUNT_CLOCK_CHOICE(choice), .PRESCALE_CHOICE(presc),
        .FREE_RUN(free_run), .FREEZE_ENABLE(freeze), .COUNT_DIRECTION(dir),
        .TIMEOUT_A(to_a), .TIMEOUT_B(to_b),
        .PERIOD_LIMIT_LOW(lim_c[15:0]), .PERIOD_LIMIT_HIGH(lim_c[31:16]),
        .EVENT_ENABLE(ev_en), .COUNTER_EVENT_CLEAR(ev_clr), .READ_LOW(rd_lo), .READ_HIGH(rd_hi),
        .COUNT_LOW_HALF(cnt_lo), .COUNT_HIGH_HALF(cnt_hi), .COUNTER_EVENT_FLAGS(flags),
        .ENABLE_SYNCED(synced), .TIMER_IRQ(irq)
    );

    // ****************************************
    // Clock, source pins and hang guard
    // ****************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h4E20)
        begin
            mismatches++;
            test_done();
        end
    end

    // ****************************************
    // Helper tasks
    // ****************************************
    task automatic test_done;
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic stop_timer;
        int n;
        n = 0;
        run = 1'b0;
        while (synced !== 1'b1 && synced !== 1'b0 || synced === 1'b1 && n < 300)
        begin
            step(1);
            n++;
        end
        check_val({31'h0, synced}, 32'h0, "enable status after stop");
        step(2);
    endtask

    task automatic start(input logic [1:0] ch, input logic [1:0] ps, input logic fr,
                         input logic dn, input logic [31:0] c);
        int n;
        n = 0;
        stop_timer();
        step(3);
        choice = ch;
        presc = ps;
        free_run = fr;
        dir = dn;
        lim_c = c;
        step(2);
        run = 1'b1;
        while (synced !== 1'b1 && n < 300)
        begin
            step(1);
            n++;
        end
        check_val({31'h0, synced}, 32'h1, "enable status after start");
    endtask

    task automatic watch(input int n);
        logic [31:0] v;
        mn = 32'hFFFFFFFF;
        mx = 32'h0;
        repeat (n)
        begin
            step(1);
            v = {cnt_hi, cnt_lo};
            if (v < mn) mn = v;
            if (v > mx) mx = v;
        end
    endtask

    task automatic tick_gap;
        logic [15:0] last;
        int n, t0;
        n = 0;
        t0 = 0;
        repeat (3)
        begin
            last = cnt_lo;
            t0 = n;
            while (cnt_lo === last && n < 3000)
            begin
                step(1);
                n++;
            end
        end
        gap = n - t0;
    endtask

    task automatic pulse_clear(input logic [3:0] bits, input logic [3:0] exp);
        ev_clr = bits;
        step(1);
        ev_clr = 4'h0;
        check_val({28'h0, flags}, {28'h0, exp}, "flags after clear");
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        resetn = 1'b0;
        run = 1'b0;
        freeze = 1'b0;
        free_run = 1'b0;
        dir = 1'b0;
        rd_lo = 1'b0;
        rd_hi = 1'b0;
        choice = CLK_BUS;
        presc = PRE_DIV4;
        to_a = 32'h3;
        to_b = 32'h2;
        lim_c = 32'h6;
        ev_en = 4'hD;
        ev_clr = 4'h0;
        mismatches = 0;
        checked = 0;
        repeat (3) @(posedge ref_clk);
        #1 resetn = 1'b1;
        step(3);
        check_val({cnt_hi, cnt_lo}, CNT_ZERO, "count after reset");
        check_val({26'h0, flags, synced, irq}, 32'h0, "status after reset");
        run = 1'b1;
        step(1);
        check_val({31'h0, synced}, 32'h0, "status one edge after run");
        step(1);
        check_val({31'h0, synced}, 32'h1, "status two edges after run");
        $display("test sync done");

        start(CLK_BUS, PRE_DIV4, 1'b0, 1'b0, 32'h6);
        step(3);
        watch(100);
        check_val(mn, CNT_ZERO, "periodic up lowest");
        check_val(mx, 32'h6, "periodic up highest");
        check_val({28'h0, flags}, 32'h5, "periodic up flags");
        check_val({31'h0, irq}, 32'h1, "interrupt raised");
        stop_timer();
        mx = {cnt_hi, cnt_lo};
        step(12);
        check_val({cnt_hi, cnt_lo}, mx, "count held when stopped");
        pulse_clear(4'h1, 4'h4);
        pulse_clear(4'h0, 4'h4);
        pulse_clear(4'hA, 4'h4);
        pulse_clear(4'h4, 4'h0);
        check_val({31'h0, irq}, 32'h0, "interrupt dropped");
        $display("test periodic up done");

        ev_en = 4'hC;
        start(CLK_BUS, PRE_DIV4, 1'b0, 1'b1, 32'hFFFFFFF8);
        step(3);
        watch(50);
        dir = 1'b0;
        watch(50);
        check_val(mx, CNT_FULL, "periodic down highest");
        check_val(mn, 32'hFFFFFFF8, "periodic down lowest");
        check_val({28'h0, flags}, 32'h4, "periodic down flags");
        stop_timer();
        pulse_clear(4'h4, 4'h0);
        $display("test periodic down done");

        for (int i = 0; i < 6; i++)
        begin
            start(src_t[i], pre_t[i], 1'b1, 1'b0, 32'h3);
            tick_gap();
            check_val(gap, gap_t[i], "tick spacing");
        end
        $display("test prescaler and sources done");

        freeze = 1'b1;
        start(CLK_BUS, PRE_DIV4, 1'b1, 1'b0, 32'h3);
        watch(60);
        check_val({31'h0, mx > 32'h3}, 32'h1, "free run passes limit");
        rd_lo = 1'b1;
        lo_save = cnt_lo;
        hi_save = cnt_hi;
        step(1);
        rd_lo = 1'b0;
        step(20);
        check_val({16'h0, cnt_lo}, {16'h0, lo_save}, "low half frozen");
        rd_hi = 1'b1;
        check_val({16'h0, cnt_hi}, {16'h0, hi_save}, "high half frozen");
        step(1);
        rd_hi = 1'b0;
        step(8);
        check_val({31'h0, cnt_lo !== lo_save}, 32'h1, "halves live again");
        stop_timer();
        $display("test freeze done");
        test_done();
    end

endmodule // gpt32_timer_test
